// [src/fpec_pkg.sv]
/*
 Constants, register map and mode states for the flash program/erase controller.
 Assumes a single AHB-Lite slave and one flash array outside on the same clock.
*/
package fpec_pkg;
   // Register byte addresses
   localparam logic [31:0] ADDR_MODE  = 32'h4000_0100;
   localparam logic [31:0] ADDR_CMD   = 32'h4000_0104;
   localparam logic [31:0] ADDR_PADDR = 32'h4000_0108;
   localparam logic [31:0] ADDR_DATA  = 32'h4000_0110;
   localparam logic [31:0] ADDR_TMR   = 32'h4000_0114;
   localparam logic [31:0] ADDR_DIRTY = 32'h4000_0118;
   localparam logic [31:0] ADDR_TICK  = 32'h4000_011C;
   localparam logic [31:0] ADDR_CRC   = 32'h4000_0120;

   // Command register bits
   localparam int CMD_PBR   = 0;
   localparam int CMD_ERS   = 1;
   localparam int CMD_PGM   = 2;
   localparam int CMD_AE    = 3;
   localparam int CMD_PROGRAM_MODE_BIT = 4;
   localparam int CMD_PAGE_BUFFER_FILL  = 5;
   localparam int CMD_WE    = 6;
   localparam int CMD_TIMER = 7;
   localparam int CMD_CRCI  = 8;
   localparam int CMD_LOW_W = 9;
   localparam int CMD_UP_LO = 24;
   localparam int CMD_UP_HI = 31;

   // Mode register read layout and access codes (values arbitrary)
   localparam int MODE_IDLE_BIT  = 8;
   localparam int MODE_DIRTY_BIT = 9;
   localparam logic [7:0] CODE_LOCK   = 8'h00;
   localparam logic [7:0] CODE_CONFIG = 8'hA5;
   localparam logic [7:0] CODE_FLASH  = 8'h5A;

   // Array geometry
   localparam int PAGE_WORDS = 32;
   localparam int PAGE_COUNT = 1024;
   localparam int IDX_W      = 5;
   localparam int PAGE_W     = 10;
   localparam int WADDR_W    = 15;

   // Timer, tick and CRC
   localparam int TMR_W   = 9;
   localparam int CNT_W   = 17;
   localparam int TICK_W  = 18;
   localparam logic [TMR_W-1:0]  TMR_RESET = 9'h0BB;
   localparam logic [7:0]        TMR_LOW   = 8'hFF;
   localparam logic [TICK_W-1:0] TICK_MAX  = 18'h3FFFF;
   localparam logic [15:0]       CRC_POLY  = 16'h1021;
   localparam logic [15:0]       CRC_INIT  = 16'hFFFF;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef enum logic [1:0] {MODE_LOCKED, MODE_CONFIG, MODE_FLASH} fpec_mode_t;
endpackage

// [src/fpec_flash_ctrl.sv]
/*
 Flash program/erase controller: AHB-Lite register slave, page buffer, operation
 timer, tick counter, read CRC and the flash read path.
 Assumes the flash array returns read data one clock after arrRdEn and performs
 word writes and erases on the single-cycle strobes it is given.
*/
`timescale 1ns/1ps
// How it works
// - Flash is 1024 pages of 128 bytes; program and page erase hit whole pages.
// - No flash contents are served on reads while flash mode is active.
// - Program and erase start only in flash mode; otherwise write-enable starts nothing.
// - Once the program command bit is set, flash reads return zero.
// - Each data word write with page-buffer fill set and command bit 0 clear lands in the page buffer at the address word slot.
// - Program command writes the whole page buffer into the addressed page.
// - Page write starts when program is set and write-enable is then set.
// - Erase with erase-all clear erases only the addressed page.
// - Erase with erase-all set clears the whole array, ignoring the address.
// - Erase starts when erase is set and write-enable is then set.
// - Timer start clears idle, counts clocks, sets idle at the terminal count.
// - Terminal count is the 9-bit timer field above eight ones.
// - Timer field resets to 0xBB; higher bits read zero.
// - The 18-bit tick counter counts while the timer runs, from the written value up to 0x3FFFF.
// - A CRC16 accumulates over every served flash read, shown in bits 15..0.
// - Setting then clearing checksum init resets the CRC before a checked read.
// - Config code unlocks command bits 24..31; writing 0x00 locks again.
// - Command bit 0 set holds the page buffer cleared.
module fpec_flash_ctrl
   import fpec_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               srst,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic                    hreadyout,
   output logic                    hresp,
   output logic [31:0]             hrdata,
   input  wire logic               flRdReq,
   input  wire logic [WADDR_W-1:0] flRdAddr,
   output logic                    flRdValid,
   output logic [31:0]             flRdData,
   output logic                    arrRdEn,
   output logic [WADDR_W-1:0]      arrRdAddr,
   input  wire logic [31:0]        arrRdData,
   output logic                    arrWrEn,
   output logic [WADDR_W-1:0]      arrWrAddr,
   output logic [31:0]             arrWrData,
   output logic                    arrPageErase,
   output logic                    arrBulkErase,
   output logic [PAGE_W-1:0]       arrErasePage,
   output logic [7:0]              upperCfg,
   output logic                    progMode
);
   fpec_mode_t          mode_q;
   logic [31:0]         cmd_q;
   logic [WADDR_W-1:0]  pageAddr_q;
   logic [31:0]         dataWord_q;
   logic [TMR_W-1:0]    tmr_q;
   logic [TICK_W-1:0]   tick_q;
   logic [15:0]         crc_q;
   logic                dirty_q;
   logic                idle_q;
   logic                busy_q;
   logic [CNT_W-1:0]    cnt_q;
   logic [31:0]         pageBuf_q [PAGE_WORDS];
   logic                pgmRun_q;
   logic [IDX_W-1:0]    pgmIdx_q;
   logic                wrPend_q;
   logic [31:0]         wrAddr_q;
   logic                rdP1_q;
   logic                rdBlk1_q;
   logic                flRdValid_q;
   logic [31:0]         flRdData_q;
   logic [31:0]         hrdata_q;
   logic                arrPageErase_q;
   logic                arrBulkErase_q;
   logic [PAGE_W-1:0]   arrErasePage_q;

   logic                addrPhase;
   logic                wrCmd;
   logic                wrData;
   logic                weRise;
   logic                timerRise;
   logic                opStart;
   logic                tmrStart;
   logic [CNT_W-1:0]    terminal;
   logic                readsBlocked;
   logic [31:0]         rdMux;

   function automatic logic [15:0] crcWord(input logic [15:0] c, input logic [31:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 31; i >= 0; i--) begin
         if (r[15] ^ d[i]) begin
            r = {r[14:0], 1'b0} ^ CRC_POLY;
         end else begin
            r = {r[14:0], 1'b0};
         end
      end
      return r;
   endfunction

   // Zero-wait slave: the write lands in the data phase after its address phase
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;
   assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);
   assign wrCmd     = wrPend_q && (wrAddr_q == ADDR_CMD);
   assign wrData    = wrPend_q && (wrAddr_q == ADDR_DATA);

   // Rising edges of write-enable and timer-run come from the bus write itself
   assign weRise    = wrCmd && hwdata[CMD_WE] && !cmd_q[CMD_WE];
   assign timerRise = wrCmd && hwdata[CMD_TIMER] && !cmd_q[CMD_TIMER];
   assign opStart   = weRise && (mode_q == MODE_FLASH) && cmd_q[CMD_PROGRAM_MODE_BIT] &&
                      (cmd_q[CMD_PGM] || cmd_q[CMD_ERS]);
   assign tmrStart  = opStart || timerRise;
   assign terminal  = {tmr_q, TMR_LOW};
   assign readsBlocked = (mode_q == MODE_FLASH) || cmd_q[CMD_PGM];

   assign upperCfg  = cmd_q[CMD_UP_HI:CMD_UP_LO];
   assign progMode  = cmd_q[CMD_PROGRAM_MODE_BIT];

   always_ff @(posedge clk) begin
      if (srst) begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 32'h0000_0000;
      end else begin
         wrPend_q <= addrPhase && hwrite;
         wrAddr_q <= haddr;
      end
   end

   always_comb begin
      rdMux = 32'h0000_0000;
      case (haddr)
         ADDR_MODE: begin
            rdMux[MODE_IDLE_BIT]  = idle_q;
            rdMux[MODE_DIRTY_BIT] = dirty_q;
            rdMux[1:0]            = mode_q;
         end
         ADDR_CMD:   rdMux = cmd_q;
         ADDR_PADDR: rdMux[WADDR_W-1:0] = pageAddr_q;
         ADDR_DATA:  rdMux = dataWord_q;
         ADDR_TMR:   rdMux[TMR_W-1:0] = tmr_q;
         ADDR_TICK:  rdMux[TICK_W-1:0] = tick_q;
         ADDR_CRC:   rdMux[15:0] = crc_q;
         default:    rdMux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         hrdata_q <= 32'h0000_0000;
      end else if (addrPhase && !hwrite) begin
         hrdata_q <= rdMux;
      end
   end

   // Mode lock: config code opens upper command bits, flash code opens the array
   always_ff @(posedge clk) begin
      if (srst) begin
         mode_q <= MODE_LOCKED;
      end else if (wrPend_q && (wrAddr_q == ADDR_MODE)) begin
         case (hwdata[7:0])
            CODE_LOCK:   mode_q <= MODE_LOCKED;
            CODE_CONFIG: mode_q <= MODE_CONFIG;
            CODE_FLASH:  mode_q <= MODE_FLASH;
            default:     mode_q <= mode_q;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cmd_q <= 32'h0000_0000;
      end else if (wrCmd) begin
         cmd_q[CMD_LOW_W-1:0] <= hwdata[CMD_LOW_W-1:0];
         if (mode_q == MODE_CONFIG) begin
            cmd_q[CMD_UP_HI:CMD_UP_LO] <= hwdata[CMD_UP_HI:CMD_UP_LO];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pageAddr_q <= '0;
         dataWord_q <= 32'h0000_0000;
         tmr_q      <= TMR_RESET;
      end else if (wrPend_q) begin
         if (wrAddr_q == ADDR_PADDR) begin
            pageAddr_q <= hwdata[WADDR_W-1:0];
         end
         if (wrAddr_q == ADDR_DATA) begin
            dataWord_q <= hwdata;
         end
         if (wrAddr_q == ADDR_TMR) begin
            tmr_q <= hwdata[TMR_W-1:0];
         end
      end
   end

   // Page buffer: one word slot per entry, selected by the address word index
   generate
      for (genvar w = 0; w < PAGE_WORDS; w++) begin : g_buf
         always_ff @(posedge clk) begin
            if (srst || cmd_q[CMD_PBR]) begin
               pageBuf_q[w] <= 32'h0000_0000;
            end else if (wrData && cmd_q[CMD_PAGE_BUFFER_FILL] &&
                         (pageAddr_q[IDX_W-1:0] == IDX_W'(w))) begin
               pageBuf_q[w] <= hwdata;
            end
         end
      end
   endgenerate

   // Set wins over the software clear
   always_ff @(posedge clk) begin
      if (srst) begin
         dirty_q <= 1'b0;
      end else if (wrData && cmd_q[CMD_PAGE_BUFFER_FILL]) begin
         dirty_q <= 1'b1;
      end else if (wrPend_q && (wrAddr_q == ADDR_DIRTY)) begin
         dirty_q <= 1'b0;
      end
   end

   // Operation timer; a new start restarts the count
   always_ff @(posedge clk) begin
      if (srst) begin
         busy_q <= 1'b0;
         idle_q <= 1'b1;
         cnt_q  <= '0;
      end else if (tmrStart) begin
         busy_q <= 1'b1;
         idle_q <= 1'b0;
         cnt_q  <= '0;
      end else if (busy_q) begin
         if (cnt_q == terminal) begin
            busy_q <= 1'b0;
            idle_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   // Page program streams all buffer words, well inside the shortest timer window
   always_ff @(posedge clk) begin
      if (srst) begin
         pgmRun_q <= 1'b0;
         pgmIdx_q <= '0;
      end else if (opStart && cmd_q[CMD_PGM]) begin
         pgmRun_q <= 1'b1;
         pgmIdx_q <= '0;
      end else if (pgmRun_q) begin
         pgmIdx_q <= pgmIdx_q + 1'b1;
         if (pgmIdx_q == IDX_W'(PAGE_WORDS - 1)) begin
            pgmRun_q <= 1'b0;
         end
      end
   end

   assign arrWrEn   = pgmRun_q;
   assign arrWrAddr = {pageAddr_q[WADDR_W-1:IDX_W], pgmIdx_q};
   assign arrWrData = pageBuf_q[pgmIdx_q];

   // Program takes priority if software set both command bits
   always_ff @(posedge clk) begin
      if (srst) begin
         arrPageErase_q <= 1'b0;
         arrBulkErase_q <= 1'b0;
         arrErasePage_q <= '0;
      end else begin
         arrPageErase_q <= opStart && !cmd_q[CMD_PGM] && !cmd_q[CMD_AE];
         arrBulkErase_q <= opStart && !cmd_q[CMD_PGM] && cmd_q[CMD_AE];
         arrErasePage_q <= pageAddr_q[WADDR_W-1:IDX_W];
      end
   end

   assign arrPageErase = arrPageErase_q;
   assign arrBulkErase = arrBulkErase_q;
   assign arrErasePage = arrErasePage_q;

   // Tick counter saturates instead of wrapping
   always_ff @(posedge clk) begin
      if (srst) begin
         tick_q <= '0;
      end else if (wrPend_q && (wrAddr_q == ADDR_TICK)) begin
         tick_q <= hwdata[TICK_W-1:0];
      end else if (busy_q && (tick_q != TICK_MAX)) begin
         tick_q <= tick_q + 1'b1;
      end
   end

   // Flash read path: array answers one cycle after the request
   assign arrRdEn   = flRdReq && !readsBlocked;
   assign arrRdAddr = flRdAddr;
   assign flRdValid = flRdValid_q;
   assign flRdData  = flRdData_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         rdP1_q      <= 1'b0;
         rdBlk1_q    <= 1'b0;
         flRdValid_q <= 1'b0;
         flRdData_q  <= 32'h0000_0000;
      end else begin
         rdP1_q      <= flRdReq;
         rdBlk1_q    <= readsBlocked;
         flRdValid_q <= rdP1_q;
         flRdData_q  <= (rdP1_q && !rdBlk1_q) ? arrRdData : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || cmd_q[CMD_CRCI]) begin
         crc_q <= CRC_INIT;
      end else if (rdP1_q && !rdBlk1_q) begin
         crc_q <= crcWord(crc_q, arrRdData);
      end
   end

   AST_IDLE_CLEAR: assert property (@(posedge clk) disable iff (srst)
      tmrStart |=> !idle_q && busy_q)
      else $error("idle not cleared by timer start");

   AST_IDLE_AT_TERMINAL: assert property (@(posedge clk) disable iff (srst)
      (busy_q && !tmrStart && (cnt_q == {tmr_q, TMR_LOW})) |=> idle_q && !busy_q)
      else $error("idle not set at terminal count");

   AST_BLOCKED_READ_ZERO: assert property (@(posedge clk) disable iff (srst)
      (rdP1_q && rdBlk1_q) |=> flRdValid && (flRdData == 32'h0000_0000))
      else $error("flash data returned while reads blocked");

   AST_NO_ARRAY_READ: assert property (@(posedge clk) disable iff (srst)
      (mode_q == MODE_FLASH) |-> !arrRdEn)
      else $error("array read in flash mode");

   AST_OP_NEEDS_FLASH: assert property (@(posedge clk) disable iff (srst)
      $rose(pgmRun_q) |-> $past(mode_q) == MODE_FLASH)
      else $error("program started outside flash mode");

   AST_PGM_FIRST_WORD: assert property (@(posedge clk) disable iff (srst)
      (opStart && cmd_q[CMD_PGM]) |=> arrWrEn && (arrWrAddr[IDX_W-1:0] == '0)
         ##31 arrWrEn && (arrWrAddr[IDX_W-1:0] == '1) ##1 !arrWrEn)
      else $error("page program did not stream the whole buffer");

   AST_PAGE_ERASE: assert property (@(posedge clk) disable iff (srst)
      arrPageErase |-> !arrBulkErase && (arrErasePage == $past(pageAddr_q[WADDR_W-1:IDX_W])))
      else $error("page erase on wrong page");

   AST_BULK_ERASE: assert property (@(posedge clk) disable iff (srst)
      (opStart && !cmd_q[CMD_PGM] && cmd_q[CMD_AE]) |=> arrBulkErase && !arrPageErase)
      else $error("bulk erase missing");

   AST_UPPER_LOCK: assert property (@(posedge clk) disable iff (srst)
      (wrCmd && (mode_q != MODE_CONFIG)) |=> $stable(cmd_q[CMD_UP_HI:CMD_UP_LO]))
      else $error("upper command bits changed while locked");

   AST_PBR_CLEARS: assert property (@(posedge clk) disable iff (srst)
      cmd_q[CMD_PBR] |=> (pageBuf_q[0] == 32'h0000_0000) && (arrWrData == 32'h0000_0000
         || pgmRun_q))
      else $error("page buffer not cleared");

   AST_TICK_SAT: assert property (@(posedge clk) disable iff (srst)
      ((tick_q == TICK_MAX) && !(wrPend_q && (wrAddr_q == ADDR_TICK))) |=> tick_q == TICK_MAX)
      else $error("tick counter wrapped");

   AST_CRC_INIT: assert property (@(posedge clk) disable iff (srst)
      cmd_q[CMD_CRCI] |=> crc_q == CRC_INIT)
      else $error("crc not initialised");

endmodule

// [dv/fpec_flash_model.sv]
/*
 Behavioural flash array standing behind the controller's array port.
 Assumes the controller's clock; read data follows one cycle after the read enable.
*/
`timescale 1ns/1ps
module fpec_flash_model
   import fpec_pkg::*;
#(
   parameter logic [31:0] ERASED = 32'hFFFF_FFFF
)
(
   input  wire logic               clk,
   input  wire logic               arrRdEn,
   input  wire logic [WADDR_W-1:0] arrRdAddr,
   output logic [31:0]             arrRdData,
   input  wire logic               arrWrEn,
   input  wire logic [WADDR_W-1:0] arrWrAddr,
   input  wire logic [31:0]        arrWrData,
   input  wire logic               arrPageErase,
   input  wire logic               arrBulkErase,
   input  wire logic [PAGE_W-1:0]  arrErasePage
);
   logic [31:0] mem [PAGE_COUNT*PAGE_WORDS];

   initial begin
      for (int i = 0; i < PAGE_COUNT*PAGE_WORDS; i++) begin
         mem[i] = 32'hC0DE_0000 ^ 32'(i);
      end
   end

   // Bus not held when idle: toggling junk so stale data never passes
   always @(posedge clk) begin
      if (arrRdEn) begin
         arrRdData <= mem[arrRdAddr];
      end else begin
         arrRdData <= ~arrRdData;
      end
   end

   always @(posedge clk) begin
      if (arrWrEn) begin
         mem[arrWrAddr] <= arrWrData;
      end
      if (arrPageErase) begin
         for (int i = 0; i < PAGE_WORDS; i++) begin
            mem[{arrErasePage, IDX_W'(i)}] <= ERASED;
         end
      end
      if (arrBulkErase) begin
         for (int i = 0; i < PAGE_COUNT*PAGE_WORDS; i++) begin
            mem[i] <= ERASED;
         end
      end
   end
endmodule

// [dv/tb_top.sv]
/*
 Self-checking bench for the flash program/erase controller.
 Assumes the flash model on the array port and a single AHB-Lite master here.
*/
`timescale 1ns/1ps
module tb_top
   import fpec_pkg::*;
;
   localparam logic [31:0] ERASED = 32'hFFFF_FFFF;
   localparam logic [31:0] PM     = 32'h1 << CMD_PROGRAM_MODE_BIT;
   logic               clk, srst, hsel, hwrite, hready, hreadyout, hresp;
   logic               flRdReq, flRdValid, arrRdEn, arrWrEn, arrPageErase, arrBulkErase;
   logic               progMode;
   logic [1:0]         htrans;
   logic [2:0]         hsize;
   logic [31:0]        haddr, hwdata, hrdata, flRdData, arrRdData, arrWrData, crc;
   logic [WADDR_W-1:0] flRdAddr, arrRdAddr, arrWrAddr;
   logic [PAGE_W-1:0]  arrErasePage, pg;
   logic [7:0]         upperCfg;
   int                 numErrors, testsRun, cycles, wrCount, pgErs, blkErs, n;

   assign hready = hreadyout;

   fpec_flash_ctrl fpec_flash_ctrl_inst (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flRdReq(flRdReq),
      .flRdAddr(flRdAddr), .flRdValid(flRdValid), .flRdData(flRdData), .arrRdEn(arrRdEn),
      .arrRdAddr(arrRdAddr), .arrRdData(arrRdData), .arrWrEn(arrWrEn), .arrWrAddr(arrWrAddr),
      .arrWrData(arrWrData), .arrPageErase(arrPageErase), .arrBulkErase(arrBulkErase),
      .arrErasePage(arrErasePage), .upperCfg(upperCfg), .progMode(progMode));

   fpec_flash_model fpec_flash_model_inst (.clk(clk), .arrRdEn(arrRdEn), .arrRdAddr(arrRdAddr),
      .arrRdData(arrRdData), .arrWrEn(arrWrEn), .arrWrAddr(arrWrAddr), .arrWrData(arrWrData),
      .arrPageErase(arrPageErase), .arrBulkErase(arrBulkErase), .arrErasePage(arrErasePage));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic final_report;
      if (numErrors == 0 && testsRun > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      testsRun++;
      if (seen !== exp) begin
         numErrors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, seen, exp);
      end
   endtask

   function automatic logic [31:0] pat(input logic [14:0] a);
      return 32'hC0DE_0000 ^ {17'h0, a};
   endfunction

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [31:0] d);
      logic fb;
      for (int i = 31; i >= 0; i--) begin
         fb = c[15] ^ d[i];
         c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0);
      end
      return c;
   endfunction

   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
      check({31'h0, hresp}, 32'h0, "response");
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, exp, "register read");
   endtask

   task automatic flread(input logic [14:0] a, input logic [31:0] exp);
      flRdReq <= 1'b1;
      flRdAddr <= a;
      @(posedge clk);
      flRdReq <= 1'b0;
      repeat (2) @(posedge clk);
      check({31'h0, flRdValid}, 32'h1, "read valid");
      check(flRdData, exp, "flash data");
   endtask

   // Polling costs two cycles a read, so the measured time is coarse
   task automatic op(input logic [31:0] cmd, input int tc);
      logic [31:0] q;
      wr(ADDR_CMD, PM | cmd);
      wr(ADDR_CMD, PM | cmd | (32'h1 << CMD_WE));
      n = 0;
      q = 32'h0;
      while (q[MODE_IDLE_BIT] !== 1'b1 && n < 3000) begin
         bus(1'b0, ADDR_MODE, 32'h0, q);
         if (n == 0) check(32'(q[MODE_IDLE_BIT]), 32'h0, "idle");
         n += 2;
      end
      check(32'(n >= tc - 6 && n <= tc + 8), 32'h1, "op time");
      wr(ADDR_CMD, PM);
   endtask

   task automatic t_reset;
      rdchk(ADDR_TMR, 32'h0BB);
      rdchk(ADDR_MODE, 32'h100);
      rdchk(ADDR_CRC, {16'h0, CRC_INIT});
      rdchk(32'h4000_0200, 32'h0);
      wr(ADDR_TMR, 32'hFFFF_FFFF);
      rdchk(ADDR_TMR, 32'h1FF);
   endtask

   task automatic t_lock;
      wr(ADDR_CMD, 32'hAB00_0000);
      // Register outputs settle after the write's last edge
      #1;
      check(32'(upperCfg), 32'h0, "locked upper");
      wr(ADDR_MODE, {24'h0, CODE_CONFIG});
      wr(ADDR_CMD, 32'hAB00_0000);
      #1;
      check(32'(upperCfg), 32'hAB, "unlocked upper");
      wr(ADDR_MODE, {24'h0, CODE_LOCK});
      wr(ADDR_CMD, PM | (32'h1 << CMD_PGM));
      #1;
      check(32'(upperCfg), 32'hAB, "relocked upper");
      check(32'(progMode), 32'h1, "program mode");
      flread(15'h0, 32'h0);
      wr(ADDR_CMD, PM | (32'h1 << CMD_PGM) | (32'h1 << CMD_WE));
      repeat (40) @(posedge clk);
      check(32'(wrCount), 32'h0, "no write outside flash mode");
      wr(ADDR_CMD, 32'h0);
   endtask

   task automatic t_crc;
      flread(15'h0, pat(15'h0));
      wr(ADDR_CMD, 32'h1 << CMD_CRCI);
      wr(ADDR_CMD, 32'h0);
      crc = {16'h0, CRC_INIT};
      for (int i = 0; i < PAGE_W; i++) begin
         flread(15'(i * 1234), pat(15'(i * 1234)));
         crc[15:0] = crc_step(crc[15:0], pat(15'(i * 1234)));
      end
      rdchk(ADDR_CRC, crc);
   endtask

   task automatic t_prog;
      pg = 10'h155;
      wr(ADDR_MODE, {24'h0, CODE_FLASH});
      flread({pg, 5'h0}, 32'h0);
      rdchk(ADDR_CRC, crc);
      wr(ADDR_DIRTY, 32'h0);
      wr(ADDR_TMR, 32'h0);
      wr(ADDR_CMD, PM | 32'h1);
      wr(ADDR_CMD, PM | (32'h1 << CMD_PAGE_BUFFER_FILL));
      for (int i = 31; i >= 0; i--) begin
         wr(ADDR_PADDR, {17'h0, pg, 5'(i)});
         wr(ADDR_DATA, 32'h1234_0000 + 32'(i));
      end
      rdchk(ADDR_MODE, 32'h302);
      wr(ADDR_DIRTY, 32'h0);
      rdchk(ADDR_MODE, 32'h102);
      wr(ADDR_CMD, PM);
      wr(ADDR_PADDR, {17'h0, pg, 5'h0});
      wrCount = 0;
      op(32'h1 << CMD_PGM, 256);
      check(32'(wrCount), 32'(PAGE_WORDS), "page write length");
      wr(ADDR_MODE, {24'h0, CODE_LOCK});
      flread({pg, 5'h0}, 32'h1234_0000);
      flread({pg, 5'h1F}, 32'h1234_001F);
   endtask

   task automatic t_erase;
      wr(ADDR_MODE, {24'h0, CODE_FLASH});
      wr(ADDR_TMR, 32'h1);
      op(32'h1 << CMD_ERS, 512);
      op(32'h1 << CMD_ERS | 32'h1 << CMD_PBR, 512);
      check(32'(pgErs), 32'h2, "page erase pulses");
      wr(ADDR_MODE, {24'h0, CODE_LOCK});
      flread({pg, 5'h7}, ERASED);
      flread({pg + 10'h1, 5'h7}, pat({pg + 10'h1, 5'h7}));
      wr(ADDR_MODE, {24'h0, CODE_FLASH});
      wr(ADDR_PADDR, 32'h0);
      op(32'h1 << CMD_ERS | 32'h1 << CMD_AE, 512);
      check(32'(blkErs), 32'h1, "bulk erase pulse");
      wr(ADDR_TMR, 32'h0);
      wr(ADDR_TICK, 32'h3FFF0);
      wr(ADDR_CMD, PM | (32'h1 << CMD_TIMER));
      repeat (300) @(posedge clk);
      rdchk(ADDR_MODE, 32'h102);
      rdchk(ADDR_TICK, 32'h3FFFF);
      wr(ADDR_CMD, 32'h0);
      wr(ADDR_MODE, {24'h0, CODE_LOCK});
      flread({pg + 10'h1, 5'h7}, ERASED);
   endtask

   always @(posedge clk) begin
      if (arrWrEn === 1'b1) begin
         check(32'(arrWrAddr), 32'({pg, wrCount[4:0]}), "write slot");
         wrCount++;
      end
      if (arrPageErase === 1'b1) begin
         check(32'(arrErasePage), 32'(pg), "erase page");
         pgErs++;
      end
      if (arrBulkErase === 1'b1) blkErs++;
      cycles++;
      if (cycles == 30000) begin
         numErrors++;
         final_report();
      end
   end

   initial begin
      {srst, hsel, hwrite, flRdReq} = 4'h8;
      {haddr, hwdata, htrans, flRdAddr, pg} = '0;
      hsize = 3'h2;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_lock();
      t_crc();
      t_prog();
      t_erase();
      final_report();
   end
endmodule
